// ---- logic/timekeeper_pkg.sv ----
// package of constants and types for the timekeeper control block
package timekeeper_pkg;
  localparam int          PATTERN_BITS   = 64;
  localparam logic [63:0] UNLOCK_PATTERN = 64'h5ca3_3ac5_5ca3_3ac5;
  localparam int          REG_COUNT      = 8;
  localparam int          PTR_W          = 6;
  // register indices inside the 64-bit image
  localparam int          HOURS_IDX      = 3;
  localparam int          DAY_IDX        = 4;
  // field positions
  localparam int          HOUR_FMT_BIT   = 7;
  localparam int          MERIDIEM_BIT   = 5;
  localparam int          ABORT_DIS_BIT  = 4;
  localparam int          OSC_STOP_BIT   = 5;
  // readable-bit masks per register, zero bits read as zero
  localparam logic [63:0] READ_MASK      = 64'hff1f_3f37_bf7f_7fff;
  // reset image: day register holds abort-disable and oscillator-stop set
  localparam logic [63:0] RESET_IMAGE    = 64'h0000_0030_0000_0000;
  // one hundredth of a second at 20 MHz
  localparam int          CLK_HZ         = 20_000_000;
  localparam int          TICK_HZ        = 100;
  localparam int          TICK_CYCLES    = CLK_HZ / TICK_HZ;
  localparam int          TICK_W         = 18;
  localparam int          FIFO_DEPTH     = 16;
  typedef enum logic [2:0] {
    ST_HUNT = 3'b001,
    ST_XFER = 3'b010,
    ST_IDLE = 3'b100
  } mode_t;
endpackage

// ---- logic/bit_fifo.sv ----
// small synchronous fifo with valid/ready on both sides and registered read data
`timescale 1ns/100ps
module bit_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk_i,  // clock
  input  wire logic             rst_n_i,    // sync reset, active low
  input  wire logic [WIDTH-1:0] in_data_i,  // write data
  input  wire logic             in_valid_i, // write request
  output      logic             in_ready_o, // not full
  output      logic [WIDTH-1:0] out_data_o, // registered read data
  output      logic             out_valid_o,// not empty
  input  wire logic             out_ready_i // read accept
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wr_ff;
  logic [AW:0]      rd_ff;
  logic [AW:0]      cnt;
  logic             push;
  logic             pop;
  logic             empty;

  assign cnt         = wr_ff - rd_ff;
  assign in_ready_o  = cnt != (AW+1)'(DEPTH);
  assign empty       = cnt == '0;
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // head word is kept in a register so the consumer sees flopped data
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wr_ff       <= '0;
      rd_ff       <= '0;
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end else begin
      if (push) begin
        mem_ff[wr_ff[AW-1:0]] <= in_data_i;
        wr_ff                 <= wr_ff + 1'b1;
      end
      if (pop || !out_valid_o) begin
        out_valid_o <= !empty;
        if (!empty) begin
          out_data_o <= mem_ff[rd_ff[AW-1:0]];
          rd_ff      <= rd_ff + 1'b1;
        end
      end
    end
  end
endmodule // bit_fifo

// ---- logic/timekeeper_core.sv ----
// hidden timekeeper: unlock matcher, serial register transfer, format and control bits
`timescale 1ns/100ps
module timekeeper_core
  import timekeeper_pkg::*;
(
  input  wire logic ref_clk_i,                // 20 MHz clock
  input  wire logic rst_n_i,                  // sync reset, active low
  input  wire logic chip_en_n_i,              // chip enable pin, active low
  input  wire logic out_en_n_i,               // output enable pin, active low
  input  wire logic write_en_n_i,             // write enable pin, active low
  input  wire logic top_address_or_abort_pin_i, // abort pin, active low
  input  wire logic serial_data_bit_i,        // data bit 0 from the bus
  output      logic serial_data_bit_o,        // data bit 0 towards the bus
  output      logic serial_data_bit_oe_o,     // high while driving data bit 0
  output      logic mem_inhibit_o,            // high while cycles belong to the timekeeper
  output      logic twelve_hour_o,            // hour format select
  output      logic meridiem_flag_o,          // afternoon in twelve-hour mode
  output      logic osc_running_o,            // oscillator running
  output      logic hundredth_tick_o          // 100 Hz timebase pulse
);
  import timekeeper_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and cycle edges
  logic [1:0] ce_s_ff, oe_s_ff, we_s_ff, rst_s_ff, dq_s_ff;
  logic       cyc_ff;
  logic       we_q_ff;
  logic       dq_q_ff;

  // a cycle is active while chip enable and either strobe are low
  wire   wr_act  = !ce_s_ff[1] && !we_s_ff[1];
  wire   rd_act  = !ce_s_ff[1] && we_s_ff[1] && !oe_s_ff[1];
  wire   cyc_act = wr_act || rd_act;
  // writes complete on the trailing edge, reads are counted at their start
  wire   wr_end  = cyc_ff && !cyc_act && we_q_ff;
  wire   rd_beg  = rd_act && !cyc_ff;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ce_s_ff  <= 2'h3;
      oe_s_ff  <= 2'h3;
      we_s_ff  <= 2'h3;
      rst_s_ff <= 2'h3;
      dq_s_ff  <= 2'h0;
      cyc_ff   <= 1'b0;
      we_q_ff  <= 1'b0;
      dq_q_ff  <= 1'b0;
    end else begin
      ce_s_ff  <= {ce_s_ff[0], chip_en_n_i};
      oe_s_ff  <= {oe_s_ff[0], out_en_n_i};
      we_s_ff  <= {we_s_ff[0], write_en_n_i};
      rst_s_ff <= {rst_s_ff[0], top_address_or_abort_pin_i};
      dq_s_ff  <= {dq_s_ff[0], serial_data_bit_i};
      cyc_ff   <= cyc_act;
      we_q_ff  <= wr_act;
      dq_q_ff  <= dq_s_ff[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // unlock matcher and transfer sequencer
  mode_t            mode_ff, nxt_mode;
  logic [PTR_W-1:0] ptr_ff, nxt_ptr;
  logic             miss_ff, nxt_miss;
  logic [63:0]      image_ff;
  logic [63:0]      shadow_ff;
  logic             bit_wr;

  wire abort_en  = !image_ff[DAY_IDX*8 + ABORT_DIS_BIT];
  wire abort_hit = abort_en && !rst_s_ff[1];
  wire last_bit  = ptr_ff == PTR_W'(PATTERN_BITS - 1);
  wire pat_ok    = dq_q_ff == UNLOCK_PATTERN[ptr_ff];

  always_comb begin
    nxt_mode = mode_ff;
    nxt_ptr  = ptr_ff;
    nxt_miss = miss_ff;
    bit_wr   = 1'b0;
    case (mode_ff)
      ST_IDLE, ST_HUNT: begin
        if (rd_beg) begin
          nxt_mode = ST_HUNT;
          nxt_ptr  = '0;
          nxt_miss = 1'b0;
        end else if (wr_end && mode_ff == ST_HUNT && !miss_ff) begin
          if (!pat_ok) begin
            nxt_miss = 1'b1;
          end else if (last_bit) begin
            nxt_mode = ST_XFER;
            nxt_ptr  = '0;
          end else begin
            nxt_ptr  = ptr_ff + 1'b1;
          end
        end
      end
      ST_XFER: begin
        if (abort_hit) begin
          nxt_mode = ST_IDLE;
          nxt_ptr  = '0;
        end else if (wr_end || rd_beg) begin
          bit_wr   = wr_end;
          nxt_ptr  = ptr_ff + 1'b1;
          if (last_bit) begin
            nxt_mode = ST_IDLE;
          end
        end
      end
      default: begin
        nxt_mode = ST_IDLE;
        nxt_ptr  = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      mode_ff <= ST_IDLE;
      ptr_ff  <= '0;
      miss_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      ptr_ff  <= nxt_ptr;
      miss_ff <= nxt_miss;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write staging: bits collect in a shadow and land in the image only when a
  // whole register is in, so an abort mid-byte never corrupts time
  wire       byte_done = bit_wr && (ptr_ff[2:0] == 3'h7);
  wire [2:0] byte_idx  = ptr_ff[5:3];
  wire [7:0] new_byte  = {dq_q_ff, shadow_ff[byte_idx*8 +: 7]};

  // byte fifo decouples the serial side from the register image update
  logic [10:0] fifo_out;
  logic        fifo_valid;
  logic        fifo_in_ready;
  logic        img_take;

  bit_fifo #(
    .WIDTH (11),
    .DEPTH (FIFO_DEPTH)
  ) u_byte_fifo (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .in_data_i   ({byte_idx, new_byte}),
    .in_valid_i  (byte_done && fifo_in_ready),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out),
    .out_valid_o (fifo_valid),
    .out_ready_i (img_take)
  );

  ////////////////////////////////////////////////////////////////////////////
  // timebase: 100 Hz enable, stopped by the oscillator-stop bit
  logic [TICK_W-1:0] div_ff;
  logic              tick_ff;
  wire osc_on   = !image_ff[DAY_IDX*8 + OSC_STOP_BIT];
  wire div_wrap = div_ff == TICK_W'(TICK_CYCLES - 1);
  wire tick_upd = tick_ff;
  // the tick owns the image for its cycle, the fifo simply waits one more
  assign img_take = fifo_valid && !tick_upd;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      div_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= osc_on && div_wrap;
      if (!osc_on || div_wrap) begin
        div_ff <= '0;
      end else begin
        div_ff <= div_ff + 1'b1;
      end
    end
  end

  // bcd hundredths counter; higher fields are advanced by software-visible
  // carry only as far as the hundredths register, a known limitation
  wire [7:0] hs     = image_ff[7:0];
  wire [7:0] hs_inc = (hs[3:0] == 4'h9) ?
                      ((hs[7:4] == 4'h9) ? 8'h00 : {hs[7:4] + 4'h1, 4'h0}) :
                      {hs[7:4], hs[3:0] + 4'h1};

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      image_ff  <= RESET_IMAGE;
      shadow_ff <= '0;
    end else begin
      if (bit_wr) begin
        shadow_ff[ptr_ff] <= dq_q_ff;
      end
      if (tick_upd) begin
        image_ff[7:0] <= hs_inc;
      end else if (img_take) begin
        image_ff[fifo_out[10:8]*8 +: 8] <= fifo_out[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path and status
  wire [63:0] read_view = image_ff & READ_MASK;
  wire [7:0]  hours     = image_ff[HOURS_IDX*8 +: 8];
  logic       dq_ff;
  logic       oe_ff;
  // the pointer steps as a read starts, so the bit is caught once and held;
  // drive lasts the whole strobe, also for bit 63 after the mode has left
  wire        drive_nxt = rd_act && (oe_ff || mode_ff == ST_XFER);
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      dq_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else begin
      if (rd_beg) begin
        dq_ff <= read_view[ptr_ff];
      end
      oe_ff <= drive_nxt;
    end
  end

  assign serial_data_bit_o    = dq_ff;
  assign serial_data_bit_oe_o = oe_ff;
  assign mem_inhibit_o        = mode_ff == ST_XFER;
  assign twelve_hour_o        = hours[HOUR_FMT_BIT];
  assign meridiem_flag_o      = hours[HOUR_FMT_BIT] && hours[MERIDIEM_BIT];
  assign osc_running_o        = osc_on;
  assign hundredth_tick_o     = tick_ff;
endmodule // timekeeper_core

// ---- verification/timekeeper_core_props.sv ----
// concurrent checks on the timekeeper core ports
`timescale 1ns/100ps
module timekeeper_core_props (
  input wire logic ref_clk_i,            // clock
  input wire logic rst_n_i,              // sync reset
  input wire logic chip_en_n_i,          // chip enable
  input wire logic out_en_n_i,           // output enable
  input wire logic write_en_n_i,         // write enable
  input wire logic serial_data_bit_o,    // read data
  input wire logic serial_data_bit_oe_o, // data drive
  input wire logic mem_inhibit_o,        // transfer mode
  input wire logic twelve_hour_o,        // hour format
  input wire logic meridiem_flag_o,      // afternoon
  input wire logic osc_running_o,        // oscillator on
  input wire logic hundredth_tick_o      // timebase
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////
  a_reset_state: assert property (!$past(rst_n_i) |-> !(osc_running_o || twelve_hour_o || mem_inhibit_o))
    else $error("outputs wrong after reset");
  a_meridiem_format: assert property (meridiem_flag_o |-> twelve_hour_o)
    else $error("meridiem in 24h mode");
  a_drive_in_xfer: assert property ($rose(serial_data_bit_oe_o) |-> $past(mem_inhibit_o))
    else $error("drive outside transfer");
  a_drive_after_read: assert property ($rose(serial_data_bit_oe_o) |->
    $past(!chip_en_n_i && !out_en_n_i && write_en_n_i, 2))
    else $error("drive without read");
  a_quiet_on_write: assert property (!write_en_n_i [*5] |-> !serial_data_bit_oe_o)
    else $error("drive during write");
  a_data_stands: assert property (serial_data_bit_oe_o && $past(serial_data_bit_oe_o) |->
    $stable(serial_data_bit_o))
    else $error("read data moved");
  a_tick_stopped: assert property (!osc_running_o && !$past(osc_running_o) |-> !hundredth_tick_o)
    else $error("tick while stopped");
  a_tick_pulse: assert property (hundredth_tick_o |=> !hundredth_tick_o)
    else $error("tick longer than a cycle");
  // format bits only change through a transfer
  a_format_steady: assert property (!mem_inhibit_o && !$past(mem_inhibit_o) && !$past(mem_inhibit_o, 2) |->
    $stable(twelve_hour_o) && $stable(meridiem_flag_o))
    else $error("format moved outside transfer");
  c_unlock: cover property ($rose(mem_inhibit_o));
  c_read: cover property ($rose(serial_data_bit_oe_o));
  c_pm: cover property ($rose(meridiem_flag_o));
endmodule // timekeeper_core_props

// ---- verification/host_bus_model.sv ----
// host processor model driving memory-style strobe cycles
`timescale 1ns/100ps
module host_bus_model (
  input  wire logic ref_clk_i, // clock
  input  wire logic dq_i,      // device data bit
  input  wire logic dq_oe_i,   // device drives data
  output      logic ce_n_o,    // chip enable
  output      logic oe_n_o,    // output enable
  output      logic we_n_o,    // write enable
  output      logic dq_o       // resolved data level
);
  logic drv = 1'b0;
  logic dbit = 1'b0;
  logic last_ff = 1'b0;
  // an undriven line toggles so a stale bit never reads as valid
  assign dq_o = drv ? dbit : (dq_oe_i ? dq_i : ~last_ff);
  always @(posedge ref_clk_i) last_ff <= dq_o;
  initial {ce_n_o, oe_n_o, we_n_o} = 3'b111;
  // len sets how slowly the host ends the cycle; data outlasts the strobes
  task automatic cycle(input logic wr, input logic d, input int len, output logic q);
    @(negedge ref_clk_i);
    {ce_n_o, oe_n_o, we_n_o, drv, dbit} = {1'b0, wr, !wr, wr, d};
    repeat (len) @(negedge ref_clk_i);
    q = dq_o;
    {ce_n_o, oe_n_o, we_n_o} = 3'b111;
    repeat (2) @(negedge ref_clk_i);
    drv = 1'b0;
    repeat (2) @(negedge ref_clk_i);
  endtask
endmodule // host_bus_model

// ---- verification/testbench.sv ----
// self-checking bench for the timekeeper core, its byte fifo reached through the core
`timescale 1ns/100ps
bind timekeeper_core timekeeper_core_props i_props (
  .ref_clk_i            (ref_clk_i),
  .rst_n_i              (rst_n_i),
  .chip_en_n_i          (chip_en_n_i),
  .out_en_n_i           (out_en_n_i),
  .write_en_n_i         (write_en_n_i),
  .serial_data_bit_o    (serial_data_bit_o),
  .serial_data_bit_oe_o (serial_data_bit_oe_o),
  .mem_inhibit_o        (mem_inhibit_o),
  .twelve_hour_o        (twelve_hour_o),
  .meridiem_flag_o      (meridiem_flag_o),
  .osc_running_o        (osc_running_o),
  .hundredth_tick_o     (hundredth_tick_o)
);
module testbench;
  import timekeeper_pkg::*;
  localparam logic [63:0] KEY  = 64'h5ca3_3ac5_5ca3_3ac5;
  localparam logic [63:0] MASK = 64'hff1f_3f37_bf7f_7fff;
  localparam logic [63:0] HI   = ~64'hff;
  logic        ref_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        abort_n = 1'b1;
  logic        ce_n, oe_n, we_n, dq, dev_q, dev_oe, inh, h12, pm, osc, tick, q;
  logic [63:0] r;
  int          bad_count = 0, tests_run = 0;
  initial forever #25 ref_clk_i = ~ref_clk_i;
  host_bus_model i_host_bus_model (.ref_clk_i(ref_clk_i), .dq_i(dev_q), .dq_oe_i(dev_oe),
    .ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n), .dq_o(dq));
  timekeeper_core i_timekeeper_core (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .chip_en_n_i(ce_n),
    .out_en_n_i(oe_n), .write_en_n_i(we_n), .top_address_or_abort_pin_i(abort_n),
    .serial_data_bit_i(dq), .serial_data_bit_o(dev_q), .serial_data_bit_oe_o(dev_oe),
    .mem_inhibit_o(inh), .twelve_hour_o(h12), .meridiem_flag_o(pm), .osc_running_o(osc),
    .hundredth_tick_o(tick));
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic unlock();
    logic b;
    i_host_bus_model.cycle(1'b0, 1'b0, 6, b);
    for (int i = 0; i < 64; i++) i_host_bus_model.cycle(1'b1, KEY[i], 6, b);
    chk("unlocked", inh, 1'b1);
  endtask
  // stretched cycles vary the host pace; reg0 bits are skipped as the clock may run
  task automatic xfer(input logic wr, input logic [63:0] img, input int lo, input int hi, output logic [63:0] got);
    logic b;
    for (int i = lo; i < hi; i++) begin
      i_host_bus_model.cycle(wr, img[i], 6 + i % 4, b);
      got[i] = b;
    end
  endtask
  task automatic look(input logic [63:0] exp);
    logic [63:0] got;
    unlock();
    xfer(1'b0, '0, 0, 64, got);
    chk("image", got & HI, exp & MASK & HI);
  endtask
  task automatic rw(input logic [63:0] img);
    logic [63:0] got;
    unlock();
    xfer(1'b1, img, 0, 64, got);
    look(img);
  endtask
  task automatic pulse_abort();
    abort_n = 1'b0;
    repeat (6) @(negedge ref_clk_i);
    abort_n = 1'b1;
    repeat (4) @(negedge ref_clk_i);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge ref_clk_i);
    bad_count++;
    finish_test();
  end
  initial begin
    repeat (16) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    chk("outputs", {h12, pm, osc, inh}, 4'h0);
    look(64'h0000_0030_0000_0000);
    rw(64'h99ff_ffc9_b2ff_ff00);
    chk("12h pm", {h12, pm, osc}, 3'b111);
    rw(64'h0000_0001_2300_0000);
    chk("24h", {h12, pm, osc}, 3'b001);
    unlock();
    // register 2 is left half written with a new value and must stay as it was
    xfer(1'b1, 64'h0000_0001_2355_0000, 0, 20, r);
    pulse_abort();
    chk("abort exit", inh, 1'b0);
    i_host_bus_model.cycle(1'b0, 1'b0, 6, q);
    chk("memory after abort", inh, 1'b0);
    look(64'h0000_0001_2300_0000);
    rw(64'h0000_0031_2300_0000);
    chk("osc stop", osc, 1'b0);
    unlock();
    xfer(1'b0, '0, 0, 8, r);
    pulse_abort();
    chk("abort ignored", inh, 1'b1);
    xfer(1'b0, '0, 8, 64, r);
    chk("rest", r & HI, 64'h0000_0031_2300_0000);
    i_host_bus_model.cycle(1'b0, 1'b0, 6, q);
    for (int i = 0; i < 64; i++) begin
      if (i == 10) i_host_bus_model.cycle(1'b0, 1'b0, 6, q);
      i_host_bus_model.cycle(1'b1, KEY[i], 6, q);
    end
    chk("broken unlock", inh, 1'b0);
    look(64'h0000_0031_2300_0000);
    // every byte crosses the core's fifo on its way into the image
    rw(64'h0000_0021_9100_0000);
    chk("12h am", {h12, pm, osc}, 3'b100);
    chk("tick held", tick, 1'b0);
    unlock();
    xfer(1'b0, '0, 0, 8, r);
    pulse_abort();
    chk("abort live", inh, 1'b0);
    finish_test();
  end
endmodule // testbench
